// File: design/prio_pkg.sv
package prio_pkg;
    localparam int unsigned ADDR_WIDTH = 4;
    localparam int unsigned DATA_WIDTH = 32;
    localparam logic [3:0] PRIORITY_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [7:0] PRIORITY_RESET = 8'h00;
    localparam logic [7:0] WRITABLE_MASK = 8'hfd;
    localparam int unsigned SMBUS_BIT = 0;
    localparam int unsigned RESERVED_BIT = 1;
    localparam int unsigned WINDOW_BIT = 2;
    localparam int unsigned DONE_BIT = 3;
    localparam int unsigned COUNTER_BIT = 4;
    localparam int unsigned FIRST_CMP_BIT = 5;
    localparam int unsigned SECOND_CMP_BIT = 6;
    localparam int unsigned TIMER_BIT = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic third_timer_priority_bit;
        logic second_comparator_priority_bit;
        logic first_comparator_priority_bit;
        logic counter_array_priority_bit;
        logic conversion_done_priority_bit;
        logic window_compare_priority_bit;
        logic reserved_bit;
        logic smbus_port_priority_bit;
    } priority_type;
endpackage

// File: design/priority_store.sv
`timescale 1ns/1ps
// Holds the priority byte; reserved bit is never stored.
module priority_store (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic write_en,
    input wire logic [7:0] write_data,
    input wire logic [7:0] write_strobe_mask,
    output logic [7:0] stored
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stored <= prio_pkg::PRIORITY_RESET;
        end else if (write_en) begin
            stored <= ((write_data & write_strobe_mask) | (stored & ~write_strobe_mask))
                & prio_pkg::WRITABLE_MASK;
        end
    end
endmodule

// File: design/extended_irq_priority_bits.sv
`timescale 1ns/1ps
// Behaviour
// - Bit 6 sets second comparator priority: 1 high, 0 low.
// - Bit 5 sets first comparator priority: 1 high, 0 low.
// - Bit 4 sets counter array priority: 1 high, 0 low.
// - Bit 3 sets conversion done priority: 1 high, 0 low.
// - Bit 2 sets window compare priority: 1 high, 0 low.
// - Bit 1 reserved: reads zero; software must write zero.
// - Bit 0 sets the SMBus port interrupt priority.
// - Bit 7 sets third timer priority: 1 high, 0 low.
module extended_irq_priority_bits (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output prio_pkg::priority_type priority_levels,
    output logic reserved_write_seen
);
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] stored;

    // Address and data may come in either order; each is latched when taken.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_take;
    wire have_w = w_held || w_take;
    wire [3:0] cur_awaddr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] cur_wdata = w_held ? w_data : s_axi_wdata;
    wire [3:0] cur_wstrb = w_held ? w_strb : s_axi_wstrb;
    wire write_fire = have_aw && have_w && !s_axi_bvalid;
    wire write_hit = cur_awaddr == prio_pkg::PRIORITY_OFFSET;
    wire status_hit = cur_awaddr == prio_pkg::STATUS_OFFSET;
    wire store_en = write_fire && write_hit && cur_wstrb[0];
    wire [7:0] lane_mask = {8{cur_wstrb[0]}};
    wire reserved_violation = store_en && cur_wdata[prio_pkg::RESERVED_BIT];
    wire clear_flag = write_fire && status_hit && cur_wstrb[0] && cur_wdata[0];
    wire read_take = s_axi_arvalid && s_axi_arready;
    wire read_hit_prio = s_axi_araddr == prio_pkg::PRIORITY_OFFSET;
    wire read_hit_stat = s_axi_araddr == prio_pkg::STATUS_OFFSET;
    wire [31:0] read_word = read_hit_prio ? {24'h000000,
        stored & prio_pkg::WRITABLE_MASK}
        : read_hit_stat ? {31'h00000000, reserved_write_seen} : 32'h00000000;
    wire [1:0] read_resp = (read_hit_prio || read_hit_stat) ?
        prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR;
    wire [1:0] write_resp = (write_hit || status_hit) ?
        prio_pkg::RESP_OKAY : prio_pkg::RESP_SLVERR;

    priority_store store (
        .aclk(aclk),
        .aresetn(aresetn),
        .write_en(store_en),
        .write_data(cur_wdata[7:0]),
        .write_strobe_mask(lane_mask),
        .stored(stored)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            aw_held <= have_aw && !write_fire;
            s_axi_awready <= !have_aw || write_fire ? !aw_take || write_fire : 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            w_held <= have_w && !write_fire;
            s_axi_wready <= !have_w || write_fire ? !w_take || write_fire : 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= prio_pkg::RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= write_resp;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Set wins over clear so a violation in the clearing cycle is kept.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reserved_write_seen <= 1'b0;
        end else if (reserved_violation) begin
            reserved_write_seen <= 1'b1;
        end else if (clear_flag) begin
            reserved_write_seen <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= prio_pkg::RESP_OKAY;
        end else if (read_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // Levels go out registered; 1 means high priority for every source.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            priority_levels <= prio_pkg::priority_type'(prio_pkg::PRIORITY_RESET);
        end else begin
            priority_levels.third_timer_priority_bit <= stored[prio_pkg::TIMER_BIT];
            priority_levels.second_comparator_priority_bit <=
                stored[prio_pkg::SECOND_CMP_BIT];
            priority_levels.first_comparator_priority_bit <=
                stored[prio_pkg::FIRST_CMP_BIT];
            priority_levels.counter_array_priority_bit <= stored[prio_pkg::COUNTER_BIT];
            priority_levels.conversion_done_priority_bit <= stored[prio_pkg::DONE_BIT];
            priority_levels.window_compare_priority_bit <= stored[prio_pkg::WINDOW_BIT];
            priority_levels.reserved_bit <= 1'b0;
            priority_levels.smbus_port_priority_bit <= stored[prio_pkg::SMBUS_BIT];
        end
    end
endmodule

// File: dv/extended_irq_priority_bits_checker.sv
`timescale 1ns/1ps
module extended_irq_priority_bits_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire prio_pkg::priority_type priority_levels,
    input wire logic reserved_write_seen
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire aw_take = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h0;
    wire hit = aw_take && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    // The byte is stored at the handshake edge and the level register follows one edge later.
    property p_bit(int k);
        hit |-> ##2 priority_levels[k] == $past(s_axi_wdata[k], 2);
    endproperty
    a_timer_bit: assert property (p_bit(7)) else $error("timer priority wrong");
    a_cmp2_bit: assert property (p_bit(6)) else $error("comparator2 priority wrong");
    a_cmp1_bit: assert property (p_bit(5)) else $error("comparator1 priority wrong");
    a_counter_bit: assert property (p_bit(4)) else $error("counter priority wrong");
    a_done_bit: assert property (p_bit(3)) else $error("done priority wrong");
    a_window_bit: assert property (p_bit(2)) else $error("window priority wrong");
    a_smbus_bit: assert property (p_bit(0)) else $error("smbus priority wrong");
    a_reserved_low: assert property (priority_levels[1] == 1'b0)
        else $error("reserved output bit set");
    a_rdata_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[1] && !(|s_axi_rdata[31:8]))
        else $error("read data upper or reserved bits set");
    a_flag_sets: assert property (hit && s_axi_wdata[1] |-> ##1 reserved_write_seen)
        else $error("reserved write not flagged");
    c_write: cover property (hit);
    c_read: cover property (s_axi_rvalid);
    c_flag: cover property ($rose(reserved_write_seen));
endmodule

// File: dv/extended_irq_priority_bits_tb_top.sv
`timescale 1ns/1ps
module extended_irq_priority_bits_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, flag = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat, rv, rs;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, reserved_write_seen;
    logic [1:0] s_axi_bresp, s_axi_rresp, bsp, rsp;
    logic [7:0] model = 8'h00;
    prio_pkg::priority_type priority_levels;
    int fails = 0, checks = 0, seed = 32'he149, i;
    always #4 aclk = ~aclk;
    extended_irq_priority_bits dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .priority_levels, .reserved_write_seen);
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bit 1 is reserved and reads back as zero; every other bit is stored as written.
    function automatic logic [7:0] expected_byte(input logic [31:0] d);
        return {d[7:2], 1'b0, d[0]};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_on;
        logic w_on;
        logic b_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        b_on = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Local flags steer the loop, since the valids above only change later in this step.
        while (aw_on || w_on || b_on) begin
            @(posedge aclk);
            if (aw_on && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_on = 1'b0;
            end
            if (b_on && s_axi_bvalid) begin
                bsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                b_on = 1'b0;
            end
        end
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar_on;
        logic r_on;
        ar_on = 1'b1;
        r_on = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar_on || r_on) begin
            @(posedge aclk);
            if (ar_on && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                ar_on = 1'b0;
            end
            if (r_on && s_axi_rvalid) begin
                rdat = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                r_on = 1'b0;
            end
        end
    endtask
    // Settling allows for the two-stage store before the outputs are compared.
    task automatic settle();
        repeat (4) @(posedge aclk);
        cmp({24'h0, priority_levels}, {24'h0, model});
        cmp({31'h0, reserved_write_seen}, {31'h0, flag});
        rd(4'h0);
        cmp(rdat, {24'h0, model});
        cmp({30'h0, rsp}, 32'h0);
    endtask
    task automatic wrap_up();
        $display("counts: %0d checks, %0d fails", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        settle();
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wr(4'h0, 32'h1 << i, 4'h1);
            model = expected_byte(32'h1 << i);
            flag = flag | (i == 1);
            settle();
        end
        $display("test walk done");
        for (i = 0; i < 24; i++) begin
            rv = $random(seed);
            rs = $random(seed);
            wr(4'h0, rv, rs[3:0]);
            if (rs[0]) model = expected_byte(rv);
            flag = flag | (rs[0] & rv[1]);
            cmp({30'h0, bsp}, 32'h0);
            settle();
        end
        $display("test random done");
        rd(4'h4);
        cmp(rdat, {31'h0, flag});
        wr(4'h4, 32'h1, 4'h1);
        flag = 1'b0;
        settle();
        wr(4'h8, 32'hff, 4'hf);
        cmp({30'h0, bsp}, 32'h2);
        rd(4'h8);
        cmp(rdat, 32'h0);
        cmp({30'h0, rsp}, 32'h2);
        settle();
        $display("test status and unmapped done");
        wr(4'h0, 32'h000000ff, 4'h1);
        cmp({30'h0, bsp}, 32'h0);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        model = 8'h00;
        flag = 1'b0;
        settle();
        $display("test reset again done");
        wrap_up();
    end
endmodule
bind extended_irq_priority_bits extended_irq_priority_bits_checker chk_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_rdata, .s_axi_rvalid, .priority_levels,
    .reserved_write_seen);
